// ### hdl/eimp_ctrl.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module eimp_ctrl #(
  parameter int PIN_COUNT = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Port pins and peripheral flags
  input wire logic [PIN_COUNT-1:0] port_pins,
  input wire logic timer_c_low_overflow_flag,
  input wire logic timer_c_high_overflow_flag,
  input wire logic comparator_rise_flag,
  input wire logic comparator_fall_flag,
  input wire logic counter_array_flag,
  input wire logic conv_done_flag,
  input wire logic conv_window_flag,
  input wire logic smbus_flag,
  // CPU side
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic irq_request,
  output logic [3:0] irq_vector,
  output logic irq_high,
  output logic cpu_halt,
  output logic osc_stop,
  output logic [PIN_COUNT-1:0] port_a_skip
);

  typedef struct packed {
    logic [7:0] ext_enable;
    logic [7:0] ext_priority;
    logic [7:0] pin_config;
    logic [7:0] base_enable;
    logic [5:0] gp_flags;
    logic [PIN_COUNT-1:0] skip;
    logic [PIN_COUNT-1:0] pin_meta;
    logic [PIN_COUNT-1:0] pin_sync;
    eimp_pkg::eimp_power_e power;
    logic high_active;
    logic low_active;
    logic [7:0] rdata;
    logic request;
    logic [3:0] vector;
    logic high;
    logic halt;
    logic stopped;
  } eimp_state_s;

  eimp_state_s cur;
  eimp_state_s next_cur;

  logic [eimp_pkg::SRC_COUNT-1:0] raw;
  logic [eimp_pkg::SRC_COUNT-1:0] enabled;
  logic [eimp_pkg::SRC_COUNT-1:0] prio;
  logic [eimp_pkg::SRC_COUNT-1:0] eligible;
  logic [3:0] vec_table [eimp_pkg::SRC_COUNT];
  logic ext_a_level;
  logic ext_b_level;
  logic any_high;
  logic any_low;
  logic [3:0] pick_vec;
  logic pick_high;
  logic pick_valid;
  logic global_on;
  logic may_present;
  logic ack_taken;
  logic wake;

  always_comb
  begin
    vec_table[eimp_pkg::SRC_EXT_A] = eimp_pkg::VEC_EXT_A;
    vec_table[eimp_pkg::SRC_EXT_B] = eimp_pkg::VEC_EXT_B;
    vec_table[eimp_pkg::SRC_SMBUS] = eimp_pkg::VEC_SMBUS;
    vec_table[eimp_pkg::SRC_CONV_WINDOW] = eimp_pkg::VEC_CONV_WINDOW;
    vec_table[eimp_pkg::SRC_CONV_DONE] = eimp_pkg::VEC_CONV_DONE;
    vec_table[eimp_pkg::SRC_COUNTER_ARRAY] = eimp_pkg::VEC_COUNTER_ARRAY;
    vec_table[eimp_pkg::SRC_COMPARATOR] = eimp_pkg::VEC_COMPARATOR;
    vec_table[eimp_pkg::SRC_TIMER_C] = eimp_pkg::VEC_TIMER_C;
  end

  // Selected pins, polarity applied; sampled only, never driven
  always_comb
  begin
    ext_a_level = cur.pin_sync[cur.pin_config[eimp_pkg::EXT_A_SELECT_LSB +: eimp_pkg::SELECT_WIDTH]]
      ~^ cur.pin_config[eimp_pkg::EXT_A_POLARITY_BIT];
    ext_b_level = cur.pin_sync[cur.pin_config[eimp_pkg::EXT_B_SELECT_LSB +: eimp_pkg::SELECT_WIDTH]]
      ~^ cur.pin_config[eimp_pkg::EXT_B_POLARITY_BIT];
  end

  always_comb
  begin
    raw[eimp_pkg::SRC_EXT_A] = ext_a_level;
    raw[eimp_pkg::SRC_EXT_B] = ext_b_level;
    raw[eimp_pkg::SRC_SMBUS] = smbus_flag;
    raw[eimp_pkg::SRC_CONV_WINDOW] = conv_window_flag;
    raw[eimp_pkg::SRC_CONV_DONE] = conv_done_flag;
    raw[eimp_pkg::SRC_COUNTER_ARRAY] = counter_array_flag;
    raw[eimp_pkg::SRC_COMPARATOR] = comparator_rise_flag | comparator_fall_flag;
    raw[eimp_pkg::SRC_TIMER_C] = timer_c_low_overflow_flag | timer_c_high_overflow_flag;
    enabled[eimp_pkg::SRC_EXT_A] = cur.base_enable[eimp_pkg::EXT_A_ENABLE_BIT];
    enabled[eimp_pkg::SRC_EXT_B] = cur.base_enable[eimp_pkg::EXT_B_ENABLE_BIT];
    enabled[eimp_pkg::SRC_SMBUS] = cur.ext_enable[eimp_pkg::SMBUS_BIT];
    enabled[eimp_pkg::SRC_CONV_WINDOW] = cur.ext_enable[eimp_pkg::CONV_WINDOW_BIT];
    enabled[eimp_pkg::SRC_CONV_DONE] = cur.ext_enable[eimp_pkg::CONV_DONE_BIT];
    enabled[eimp_pkg::SRC_COUNTER_ARRAY] = cur.ext_enable[eimp_pkg::COUNTER_ARRAY_BIT];
    enabled[eimp_pkg::SRC_COMPARATOR] = cur.ext_enable[eimp_pkg::COMPARATOR_BIT];
    enabled[eimp_pkg::SRC_TIMER_C] = cur.ext_enable[eimp_pkg::TIMER_C_BIT];
    prio = '0;
    prio[eimp_pkg::SRC_SMBUS] = cur.ext_priority[eimp_pkg::SMBUS_BIT];
    prio[eimp_pkg::SRC_CONV_WINDOW] = cur.ext_priority[eimp_pkg::CONV_WINDOW_BIT];
    prio[eimp_pkg::SRC_CONV_DONE] = cur.ext_priority[eimp_pkg::CONV_DONE_BIT];
    prio[eimp_pkg::SRC_COUNTER_ARRAY] = cur.ext_priority[eimp_pkg::COUNTER_ARRAY_BIT];
    prio[eimp_pkg::SRC_COMPARATOR] = cur.ext_priority[eimp_pkg::COMPARATOR_BIT];
    prio[eimp_pkg::SRC_TIMER_C] = cur.ext_priority[eimp_pkg::TIMER_C_BIT];
  end

  // Global enable over all masks; stop blocks everything
  assign global_on = cur.base_enable[eimp_pkg::GLOBAL_ENABLE_BIT]
    && cur.power != eimp_pkg::EIMP_STOP;
  assign eligible = global_on ? (raw & enabled) : '0;

  assign any_high = |(eligible & prio);
  assign any_low = |(eligible & ~prio);

  // Any enabled request, at either level, ends idle
  assign wake = cur.power == eimp_pkg::EIMP_IDLE && (any_high || any_low);

  // The CPU took the request that stands in the same cycle as its ack
  assign ack_taken = irq_ack && cur.request;

  // A new request may interrupt only a lower running level
  assign may_present = pick_valid && !cur.high_active
    && (pick_high || !cur.low_active);

  // High level first, then lowest vector number within a level
  always_comb
  begin
    pick_vec = 4'h0;
    pick_high = 1'b0;
    pick_valid = 1'b0;
    for (int i = eimp_pkg::SRC_COUNT - 1; i >= 0; i--)
    begin
      if (eligible[i] && (prio[i] || !any_high))
      begin
        pick_vec = vec_table[i];
        pick_high = prio[i];
        pick_valid = 1'b1;
      end
    end
  end

  always_comb
  begin
    next_cur = cur;
    next_cur.pin_meta = port_pins;
    next_cur.pin_sync = cur.pin_meta;
    next_cur.rdata = eimp_pkg::ZERO_BYTE;
    // Register writes
    if (reg_write)
    begin
      if (reg_addr == eimp_pkg::EXT_ENABLE_ADDR)
      begin
        next_cur.ext_enable = reg_wdata & eimp_pkg::EXT_WRITE_MASK;
      end
      else if (reg_addr == eimp_pkg::EXT_PRIORITY_ADDR)
      begin
        next_cur.ext_priority = reg_wdata & eimp_pkg::EXT_WRITE_MASK;
      end
      else if (reg_addr == eimp_pkg::PIN_CONFIG_ADDR)
      begin
        next_cur.pin_config = reg_wdata;
      end
      else if (reg_addr == eimp_pkg::BASE_ENABLE_ADDR)
      begin
        next_cur.base_enable = reg_wdata;
      end
      else if (reg_addr == eimp_pkg::PORT_A_SKIP_ADDR)
      begin
        next_cur.skip = reg_wdata[PIN_COUNT-1:0];
      end
      else if (reg_addr == eimp_pkg::POWER_CONTROL_ADDR)
      begin
        next_cur.gp_flags = reg_wdata[7:eimp_pkg::FLAG_LSB];
        // Mode bits act only while running; stop is left by reset alone
        if (cur.power != eimp_pkg::EIMP_RUN)
        begin
          next_cur.power = cur.power;
        end
        else if (reg_wdata[eimp_pkg::STOP_BIT])
        begin
          next_cur.power = eimp_pkg::EIMP_STOP;
        end
        else if (reg_wdata[eimp_pkg::IDLE_BIT])
        begin
          next_cur.power = eimp_pkg::EIMP_IDLE;
        end
      end
    end
    // Register reads, data one cycle later
    if (reg_read)
    begin
      if (reg_addr == eimp_pkg::EXT_ENABLE_ADDR)
      begin
        next_cur.rdata = cur.ext_enable;
      end
      else if (reg_addr == eimp_pkg::EXT_PRIORITY_ADDR)
      begin
        next_cur.rdata = cur.ext_priority;
      end
      else if (reg_addr == eimp_pkg::PIN_CONFIG_ADDR)
      begin
        next_cur.rdata = cur.pin_config;
      end
      else if (reg_addr == eimp_pkg::BASE_ENABLE_ADDR)
      begin
        next_cur.rdata = cur.base_enable;
      end
      else if (reg_addr == eimp_pkg::PORT_A_SKIP_ADDR)
      begin
        next_cur.rdata = cur.skip;
      end
      else if (reg_addr == eimp_pkg::POWER_CONTROL_ADDR)
      begin
        next_cur.rdata = {cur.gp_flags, 2'b00};
      end
      else if (reg_addr == eimp_pkg::STATUS_ADDR)
      begin
        next_cur.rdata = {cur.high_active, cur.low_active, 4'h0, cur.power};
      end
    end
    // Enabled request wakes from idle only
    if (wake)
    begin
      next_cur.power = eimp_pkg::EIMP_RUN;
    end
    // Handler nesting
    if (ack_taken)
    begin
      if (cur.high)
      begin
        next_cur.high_active = 1'b1;
      end
      else
      begin
        next_cur.low_active = 1'b1;
      end
    end
    else if (irq_return)
    begin
      if (cur.high_active)
      begin
        next_cur.high_active = 1'b0;
      end
      else
      begin
        next_cur.low_active = 1'b0;
      end
    end
    // Present request if it may preempt the running level
    next_cur.request = may_present && !ack_taken;
    next_cur.vector = pick_vec;
    next_cur.high = pick_high;
    // Halt and stop outputs registered with the mode itself
    next_cur.halt = next_cur.power != eimp_pkg::EIMP_RUN;
    next_cur.stopped = next_cur.power == eimp_pkg::EIMP_STOP;
  end

  // Reset returns to run, so the CPU restarts at its reset vector
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cur <= '{
        ext_enable: eimp_pkg::EXT_ENABLE_RESET,
        ext_priority: eimp_pkg::EXT_PRIORITY_RESET,
        pin_config: eimp_pkg::PIN_CONFIG_RESET,
        base_enable: eimp_pkg::ZERO_BYTE,
        gp_flags: '0,
        skip: '0,
        pin_meta: '0,
        pin_sync: '0,
        power: eimp_pkg::EIMP_RUN,
        high_active: 1'b0,
        low_active: 1'b0,
        rdata: eimp_pkg::ZERO_BYTE,
        request: 1'b0,
        vector: 4'h0,
        high: 1'b0,
        halt: 1'b0,
        stopped: 1'b0
      };
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign irq_request = cur.request;
  assign irq_vector = cur.vector;
  assign irq_high = cur.high;
  assign cpu_halt = cur.halt;
  assign osc_stop = cur.stopped;
  assign port_a_skip = cur.skip;

endmodule : eimp_ctrl
`default_nettype wire

// ### common/eimp_pkg.sv
package eimp_pkg;
  // Register offsets
  localparam logic [7:0] EXT_ENABLE_ADDR = 8'hE6;
  localparam logic [7:0] PIN_CONFIG_ADDR = 8'hF4;
  localparam logic [7:0] EXT_PRIORITY_ADDR = 8'hF6;
  localparam logic [7:0] BASE_ENABLE_ADDR = 8'hA8;
  localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] PORT_A_SKIP_ADDR = 8'hD4;
  localparam logic [7:0] STATUS_ADDR = 8'hD5;
  // Reset values
  localparam logic [7:0] EXT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] PIN_CONFIG_RESET = 8'h01;
  localparam logic [7:0] EXT_PRIORITY_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Writable bits of extended enable and priority
  localparam logic [7:0] EXT_WRITE_MASK = 8'hBD;
  // Field positions
  localparam int TIMER_C_BIT = 7;
  localparam int COMPARATOR_BIT = 5;
  localparam int COUNTER_ARRAY_BIT = 4;
  localparam int CONV_DONE_BIT = 3;
  localparam int CONV_WINDOW_BIT = 2;
  localparam int SMBUS_BIT = 0;
  localparam int GLOBAL_ENABLE_BIT = 7;
  localparam int EXT_A_ENABLE_BIT = 0;
  localparam int EXT_B_ENABLE_BIT = 2;
  localparam int EXT_B_POLARITY_BIT = 7;
  localparam int EXT_B_SELECT_LSB = 4;
  localparam int EXT_A_POLARITY_BIT = 3;
  localparam int EXT_A_SELECT_LSB = 0;
  localparam int SELECT_WIDTH = 3;
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int FLAG_LSB = 2;
  // Source indices in the request vector, in vector order
  localparam int SRC_EXT_A = 0;
  localparam int SRC_EXT_B = 1;
  localparam int SRC_SMBUS = 2;
  localparam int SRC_CONV_WINDOW = 3;
  localparam int SRC_CONV_DONE = 4;
  localparam int SRC_COUNTER_ARRAY = 5;
  localparam int SRC_COMPARATOR = 6;
  localparam int SRC_TIMER_C = 7;
  localparam int SRC_COUNT = 8;
  // Vector numbers per source
  localparam logic [3:0] VEC_EXT_A = 4'h0;
  localparam logic [3:0] VEC_EXT_B = 4'h2;
  localparam logic [3:0] VEC_SMBUS = 4'h7;
  localparam logic [3:0] VEC_CONV_WINDOW = 4'h9;
  localparam logic [3:0] VEC_CONV_DONE = 4'hA;
  localparam logic [3:0] VEC_COUNTER_ARRAY = 4'hB;
  localparam logic [3:0] VEC_COMPARATOR = 4'hC;
  localparam logic [3:0] VEC_TIMER_C = 4'hE;

  typedef enum logic [1:0] {
    EIMP_RUN = 2'b00,
    EIMP_IDLE = 2'b01,
    EIMP_STOP = 2'b10
  } eimp_power_e;
endpackage : eimp_pkg

// ### testbench/eimp_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module eimp_ctrl_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Sources and CPU side
  input wire logic timer_c_low_overflow_flag,
  input wire logic timer_c_high_overflow_flag,
  input wire logic irq_ack,
  input wire logic irq_request,
  input wire logic [3:0] irq_vector,
  input wire logic irq_high,
  input wire logic cpu_halt,
  input wire logic osc_stop
);
  logic glob;
  // Shadow of the global enable bit
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
      glob <= 1'b0;
    else if (reg_write && reg_addr == 8'hA8)
      glob <= reg_wdata[7];
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_RSVD_ZERO: assert property ($past(reg_read && reg_addr inside {8'hE6, 8'hF6})
    |-> reg_rdata[6] == 1'b0 && reg_rdata[1] == 1'b0) else $error("reserved bit read as one");
  AST_PWR_READ: assert property ($past(reg_read && reg_addr == 8'h87)
    |-> reg_rdata[1:0] == 2'b00) else $error("mode bits read as one");
  AST_GLOBAL: assert property (!glob && !$past(glob) |-> !irq_request)
    else $error("request with global enable off");
  AST_TIMER_CAUSE: assert property ($rose(irq_request) && irq_vector == 4'hE
    |-> $past(timer_c_low_overflow_flag || timer_c_high_overflow_flag))
    else $error("timer vector without flag");
  AST_HIGH_ACK: assert property (irq_ack && irq_high |=> !irq_request)
    else $error("request stands after high ack");
  AST_HALT_IDLE: assert property (reg_write && reg_addr == 8'h87 && reg_wdata[1:0] == 2'b01
    |=> cpu_halt) else $error("idle write did not halt");
  AST_STOP_ENTER: assert property (reg_write && reg_addr == 8'h87 && reg_wdata[1:0] == 2'b11
    |=> osc_stop && cpu_halt) else $error("stop write did not stop");
  AST_STOP_HOLD: assert property (osc_stop |=> osc_stop && !irq_request)
    else $error("stop left without reset");
  AST_WAKE: assert property ($rose(irq_request) && !osc_stop |-> !cpu_halt)
    else $error("request while still halted");
  cover property (irq_ack && irq_high);
  cover property ($fell(cpu_halt));
  cover property (osc_stop);
endmodule : eimp_ctrl_chk
bind eimp_ctrl eimp_ctrl_chk u_chk (.clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .timer_c_low_overflow_flag, .timer_c_high_overflow_flag, .irq_ack, .irq_request,
  .irq_vector, .irq_high, .cpu_halt, .osc_stop);
`default_nettype wire

// ### testbench/eimp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module eimp_cpu_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Behaviour
  input wire logic serve,
  input wire logic slow,
  // Interrupt handshake
  input wire logic irq_request,
  output logic irq_ack,
  output logic irq_return
);
  int depth;
  int run;
  int seen;
  // Accepts requests and returns from nested handlers
  always @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      depth = 0;
      run = 0;
      seen = 0;
    end
    else
    begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      seen = (irq_request && !irq_ack) ? seen + 1 : 0;
      if (serve && seen > (slow ? 3 : 0))
      begin
        irq_ack <= 1'b1;
        depth++;
        run = 12;
        seen = 0;
      end
      else if (depth > 0 && run == 0)
      begin
        irq_return <= 1'b1;
        depth--;
        run = 12;
      end
      else if (run > 0)
        run--;
    end
endmodule : eimp_cpu_model
`default_nettype wire

// ### testbench/eimp_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eimp_ctrl_tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, port_pins = 8'h00, src = 8'h00;
  logic reg_write = 1'b0, reg_read = 1'b0, serve = 1'b0, slow = 1'b0;
  logic [7:0] reg_rdata, port_a_skip;
  logic irq_ack, irq_return, irq_request, irq_high, cpu_halt, osc_stop;
  logic [3:0] irq_vector;
  logic [7:0] en_t [8] = '{8'h80, 8'h80, 8'h20, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
  logic [3:0] vec_t [8] = '{4'hE, 4'hE, 4'hC, 4'hC, 4'hB, 4'hA, 4'h9, 4'h7};
  int errors = 0;
  int samples_checked = 0;
  always #2.5 clock = ~clock;
  eimp_ctrl DUT (.clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .port_pins, .timer_c_low_overflow_flag(src[0]), .timer_c_high_overflow_flag(src[1]),
    .comparator_rise_flag(src[2]), .comparator_fall_flag(src[3]), .counter_array_flag(src[4]),
    .conv_done_flag(src[5]), .conv_window_flag(src[6]), .smbus_flag(src[7]), .irq_ack,
    .irq_return, .irq_request, .irq_vector, .irq_high, .cpu_halt, .osc_stop, .port_a_skip);
  eimp_cpu_model cpu (.clock, .rstn, .serve, .slow, .irq_request, .irq_ack, .irq_return);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic set(input logic [7:0] s, input logic [7:0] p);
    @(posedge clock);
    src <= s;
    port_pins <= p;
  endtask : set
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    #100000;
    errors++;
    end_sim();
  end
  initial
  begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd(8'hE6, 8'h00);
    rd(8'hF4, 8'h01);
    rd(8'hF6, 8'h00);
    wr(8'hE6, 8'hBD);
    rd(8'hE6, 8'hBD);
    wr(8'hF6, 8'hBD);
    rd(8'hF6, 8'hBD);
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
    wr(8'hF6, 8'h00);
    $display("registers done");
    wr(8'hA8, 8'h80);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'hE6, 8'h00);
      set(8'h01 << i, 8'h00);
      cyc(4);
      chk({7'h00, irq_request}, 8'h00);
      wr(8'hE6, en_t[i]);
      cyc(2);
      chk({irq_request, irq_high, 2'b00, irq_vector}, {4'h8, vec_t[i]});
      set(8'h00, 8'h00);
    end
    $display("masks done");
    set(8'h81, 8'h00);
    wr(8'hE6, 8'h81);
    wr(8'hF6, 8'h80);
    cyc(2);
    chk({irq_request, irq_high, 2'b00, irq_vector}, 8'hCE);
    wr(8'hF6, 8'h01);
    cyc(2);
    chk({irq_request, irq_high, 2'b00, irq_vector}, 8'hC7);
    wr(8'hF6, 8'h00);
    cyc(2);
    chk({irq_request, irq_high, 2'b00, irq_vector}, 8'h87);
    wr(8'hA8, 8'h00);
    cyc(3);
    chk({7'h00, irq_request}, 8'h00);
    set(8'h80, 8'h00);
    wr(8'hF6, 8'h80);
    slow <= 1'b1;
    serve <= 1'b1;
    wr(8'hA8, 8'h80);
    cyc(8);
    set(8'h81, 8'h00);
    cyc(2);
    chk({irq_request, irq_high, 2'b00, irq_vector}, 8'hCE);
    cyc(4);
    chk({7'h00, irq_request}, 8'h00);
    set(8'h00, 8'h00);
    rd(8'hD5, 8'hC0);
    cyc(60);
    rd(8'hD5, 8'h00);
    serve <= 1'b0;
    $display("priority done");
    wr(8'hA8, 8'h81);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'hF4, {5'h01, i[2:0]});
      set(8'h00, 8'h01 << i);
      cyc(4);
      chk({irq_request, irq_high, 2'b00, irq_vector}, 8'h80);
      set(8'h00, 8'h00);
      cyc(4);
      chk({7'h00, irq_request}, 8'h00);
    end
    wr(8'hA8, 8'h84);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'hF4, {1'b0, i[2:0], 4'h0});
      set(8'h00, ~(8'h01 << i));
      cyc(4);
      chk({irq_request, irq_high, 2'b00, irq_vector}, 8'h82);
      set(8'h00, 8'hFF);
      cyc(4);
      chk({7'h00, irq_request}, 8'h00);
    end
    wr(8'hD4, 8'h5A);
    cyc(1);
    chk(port_a_skip, 8'h5A);
    $display("pins done");
    wr(8'hA8, 8'h80);
    wr(8'hE6, 8'h01);
    wr(8'hF6, 8'h00);
    slow <= 1'b0;
    serve <= 1'b1;
    wr(8'h87, 8'h01);
    cyc(1);
    chk({7'h00, cpu_halt}, 8'h01);
    rd(8'h87, 8'h00);
    rd(8'hE6, 8'h01);
    set(8'h80, 8'hFF);
    cyc(1);
    chk({6'h00, cpu_halt, irq_request}, 8'h01);
    set(8'h00, 8'hFF);
    cyc(30);
    chk({7'h00, cpu_halt}, 8'h00);
    $display("idle done");
    wr(8'h87, 8'h03);
    cyc(1);
    chk({6'h00, osc_stop, cpu_halt}, 8'h03);
    set(8'h80, 8'hFF);
    cyc(4);
    chk({5'h00, osc_stop, cpu_halt, irq_request}, 8'h06);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    set(8'h00, 8'hFF);
    cyc(1);
    chk({6'h00, osc_stop, cpu_halt}, 8'h00);
    rd(8'hE6, 8'h00);
    $display("stop done");
    end_sim();
  end
endmodule : eimp_ctrl_tb
`default_nettype wire
